//--- hw/svr_top.sv
// Supervisor core: channel fault flags, stretched system reset, watchdog, AXI4-Lite regs.
// Assumes comparator results arrive as digital levels (1 = above threshold).
//
// What this block does
// - A kick input that holds one level longer than the watchdog timeout asserts reset and clears the timer.
// - The watchdog timer clears while reset is asserted and on every rising or falling kick edge.
// - After reset the watchdog allows a 54 s startup window for the first kick edge before it resets.
// - A kick input detected as open disables the watchdog entirely.
// - Each channel flag is low while its channel is below threshold and returns high with no delay.
// - Manual reset low drives the reset output low at once and holds it while low.
// - After manual reset rises the reset output stays low for one full reset timeout.
// - With timeout select high the internal reset timeout of at least 140 ms is used.
// - Otherwise the reset timeout is 2.06 Mohm times the programmed capacitance.
// - Any channel below threshold asserts reset, released one timeout after all are good.
// - Margin low drives every channel flag and the reset output high regardless of the channels; irq is not forced.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module svr_top #(
    parameter logic [31:0] WDOG_CYCLES    = svr_pkg::WDOG_CYC,
    parameter logic [31:0] STARTUP_CYCLES = svr_pkg::STARTUP_CYC,
    parameter logic [31:0] INT_RST_CYCLES = svr_pkg::INT_RST_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        monitor_chan_5,
    input  wire logic        monitor_chan_6,
    input  wire logic        monitor_chan_7,
    input  wire logic        monitor_chan_8,
    input  wire logic        watchdog_kick_in,
    input  wire logic        watchdog_open,
    input  wire logic        manual_reset_n,
    input  wire logic        timeout_select,
    input  wire logic        margin_n,
    output logic             chan_fault_flag_5,
    output logic             chan_fault_flag_6,
    output logic             chan_fault_flag_7,
    output logic             chan_fault_flag_8,
    output logic             sys_reset_n,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    if (WDOG_CYCLES < 32'h2 || STARTUP_CYCLES < 32'h2 || INT_RST_CYCLES < 32'h1) begin : g_bad_cfg
        $error("svr_top: timeout counts too small");
    end

    // Synchronised inputs
    logic [5:0] sync_q;
    logic [3:0] chan_s;
    logic       man_rst_s;
    logic       kick_s;

    svr_sync #(.W(6), .INIT(6'h3f)) u_sync (
        .clk   (mclk),
        .rst_n (rst_n),
        .d     ({watchdog_kick_in, manual_reset_n, monitor_chan_8, monitor_chan_7,
                 monitor_chan_6, monitor_chan_5}),
        .q     (sync_q)
    );

    assign chan_s = sync_q[3:0];
    assign man_rst_s = sync_q[4];
    assign kick_s = sync_q[5];

    // Registers
    logic [31:0]       ctrl_q;
    logic [31:0]       cap_q;
    logic [svr_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_ev;
    logic              kick_d_q, man_rst_d_q;
    logic [3:0]        chan_d_q;
    logic              started_q, arm1_q, arm2_q, arm3_q;
    logic [31:0]       wd_cnt_q, wd_cnt_d;
    logic [31:0]       st_cnt_q, st_cnt_d;
    svr_pkg::svr_rst_state_t state_q, state_d;
    logic [3:0]        flag_q;
    logic              rst_out_q, irq_q;

    // Watchdog
    logic        kick_edge, wd_active, rst_asserted, wd_clear, wd_expire;
    logic [31:0] wd_limit;

    assign kick_edge    = (kick_s ^ kick_d_q) & arm3_q;
    assign wd_active    = ctrl_q[svr_pkg::CTRL_WDOG_EN] & ~watchdog_open;
    assign rst_asserted = (state_q != svr_pkg::RS_RUN);
    assign wd_clear     = ~wd_active | rst_asserted | kick_edge;
    assign wd_limit     = started_q ? WDOG_CYCLES : STARTUP_CYCLES;
    assign wd_expire    = ~wd_clear & (wd_cnt_q == wd_limit - 32'h1);
    assign wd_cnt_d     = (wd_clear | wd_expire) ? 32'h0 : wd_cnt_q + 32'h1;

    // Reset generator
    logic        cause;
    logic [31:0] cap_cyc, rst_limit;

    assign cause     = ~(&chan_s) | ~man_rst_s;
    assign cap_cyc   = 32'(64'(cap_q[svr_pkg::CAP_W-1:0]) * svr_pkg::CYC_PER_PF);
    assign rst_limit = timeout_select ? INT_RST_CYCLES
                     : (cap_cyc == 32'h0 ? 32'h1 : cap_cyc);

    always_comb begin
        state_d  = state_q;
        st_cnt_d = st_cnt_q;
        case (state_q)
            svr_pkg::RS_HOLD: begin
                st_cnt_d = 32'h0;
                if (!cause) begin
                    state_d = svr_pkg::RS_STRETCH;
                end
            end
            svr_pkg::RS_STRETCH: begin
                if (cause) begin
                    state_d  = svr_pkg::RS_HOLD;
                    st_cnt_d = 32'h0;
                end else if (st_cnt_q >= rst_limit - 32'h1) begin
                    state_d  = svr_pkg::RS_RUN;
                    st_cnt_d = 32'h0;
                end else begin
                    st_cnt_d = st_cnt_q + 32'h1;
                end
            end
            svr_pkg::RS_RUN: begin
                st_cnt_d = 32'h0;
                if (cause) begin
                    state_d = svr_pkg::RS_HOLD;
                end else if (wd_expire) begin
                    state_d = svr_pkg::RS_STRETCH;
                end
            end
            default: begin
                state_d  = svr_pkg::RS_HOLD;
                st_cnt_d = 32'h0;
            end
        endcase
    end

    assign irq_ev = {state_q == svr_pkg::RS_STRETCH && state_d == svr_pkg::RS_RUN,
                     man_rst_d_q & ~man_rst_s,
                     |(chan_d_q & ~chan_s),
                     wd_expire};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= svr_pkg::RS_STRETCH;
            st_cnt_q  <= 32'h0;
            wd_cnt_q  <= 32'h0;
            started_q <= 1'b0;
            kick_d_q  <= 1'b1;
            man_rst_d_q <= 1'b1;
            {arm3_q, arm2_q, arm1_q} <= 3'h0;
            chan_d_q  <= 4'hf;
        end else begin
            state_q   <= state_d;
            st_cnt_q  <= st_cnt_d;
            wd_cnt_q  <= wd_cnt_d;
            started_q <= rst_asserted ? 1'b0 : (started_q | kick_edge);
            kick_d_q  <= kick_s;
            man_rst_d_q <= man_rst_s;
            {arm3_q, arm2_q, arm1_q} <= {arm2_q, arm1_q, 1'b1};
            chan_d_q  <= chan_s;
        end
    end

    // Pin outputs; flags and reset forced high while margin is low, irq not
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q    <= 4'hf;
            rst_out_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            flag_q    <= margin_n ? chan_s : 4'hf;
            rst_out_q <= margin_n ? (state_d == svr_pkg::RS_RUN) : 1'b1;
            irq_q     <= |(irq_stat_d & irq_en_q);
        end
    end

    assign chan_fault_flag_5 = flag_q[0];
    assign chan_fault_flag_6 = flag_q[1];
    assign chan_fault_flag_7 = flag_q[2];
    assign chan_fault_flag_8 = flag_q[3];
    assign sys_reset_n       = rst_out_q;
    assign irq               = irq_q;

    // AXI4-Lite slave
    logic        aw_hold_q, w_hold_q, bvalid_q, awready_q, wready_q;
    logic        rvalid_q, arready_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q, wmask, rd_mux;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;
    logic        aw_take, w_take, do_wr, ar_take, aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
    logic        wr_hit, rd_hit, wr_ctrl, wr_cap, wr_clr, wr_en;

    assign aw_take   = s_axi_awvalid & awready_q;
    assign w_take    = s_axi_wvalid & wready_q;
    assign do_wr     = aw_hold_q & w_hold_q & ~bvalid_q;
    assign aw_hold_d = do_wr ? 1'b0 : (aw_hold_q | aw_take);
    assign w_hold_d  = do_wr ? 1'b0 : (w_hold_q | w_take);
    assign bvalid_d  = do_wr | (bvalid_q & ~s_axi_bready);
    assign ar_take   = s_axi_arvalid & arready_q;
    assign rvalid_d  = ar_take | (rvalid_q & ~s_axi_rready);
    assign wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    assign wr_ctrl = do_wr && awaddr_q == svr_pkg::OFS_CTRL;
    assign wr_cap  = do_wr && awaddr_q == svr_pkg::OFS_TMO_CAP;
    assign wr_clr  = do_wr && awaddr_q == svr_pkg::OFS_IRQ_CLR;
    assign wr_en   = do_wr && awaddr_q == svr_pkg::OFS_IRQ_EN;
    assign wr_hit  = wr_ctrl | wr_cap | wr_clr | wr_en
                   | awaddr_q == svr_pkg::OFS_STATUS | awaddr_q == svr_pkg::OFS_IRQ_STAT;
    assign rd_hit  = s_axi_araddr == svr_pkg::OFS_CTRL | s_axi_araddr == svr_pkg::OFS_TMO_CAP
                   | s_axi_araddr == svr_pkg::OFS_STATUS | s_axi_araddr == svr_pkg::OFS_IRQ_STAT
                   | s_axi_araddr == svr_pkg::OFS_IRQ_CLR | s_axi_araddr == svr_pkg::OFS_IRQ_EN;

    // Set wins over clear
    assign irq_stat_d = (irq_stat_q & ~(wr_clr ? wdata_q[3:0] & wmask[3:0] : 4'h0)) | irq_ev;

    assign rd_mux =
        s_axi_araddr == svr_pkg::OFS_CTRL     ? ctrl_q :
        s_axi_araddr == svr_pkg::OFS_TMO_CAP  ? cap_q :
        s_axi_araddr == svr_pkg::OFS_STATUS   ? {24'h0, ~margin_n, ~wd_active, ~started_q,
                                                 rst_asserted, ~chan_s} :
        s_axi_araddr == svr_pkg::OFS_IRQ_STAT ? {28'h0, irq_stat_q} :
        s_axi_araddr == svr_pkg::OFS_IRQ_EN   ? {28'h0, irq_en_q} : 32'h0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q  <= 1'b0;
            w_hold_q   <= 1'b0;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= svr_pkg::RESP_OKAY;
            awaddr_q   <= 8'h0;
            wdata_q    <= 32'h0;
            wstrb_q    <= 4'h0;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0;
            rresp_q    <= svr_pkg::RESP_OKAY;
        end else begin
            aw_hold_q  <= aw_hold_d;
            w_hold_q   <= w_hold_d;
            awready_q  <= ~aw_hold_d & ~bvalid_d;
            wready_q   <= ~w_hold_d & ~bvalid_d;
            bvalid_q   <= bvalid_d;
            arready_q  <= ~rvalid_d;
            rvalid_q   <= rvalid_d;
            if (aw_take) begin
                awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                bresp_q <= wr_hit ? svr_pkg::RESP_OKAY : svr_pkg::RESP_SLVERR;
            end
            if (ar_take) begin
                rdata_q <= rd_hit ? rd_mux : 32'h0;
                rresp_q <= rd_hit ? svr_pkg::RESP_OKAY : svr_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= svr_pkg::CTRL_RST;
            cap_q      <= svr_pkg::TMO_CAP_RST;
            irq_en_q   <= '0;
            irq_stat_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask & 32'h1);
            end
            if (wr_cap) begin
                cap_q <= (cap_q & ~wmask) | (wdata_q & wmask & 32'h00ff_ffff);
            end
            if (wr_en) begin
                irq_en_q <= (irq_en_q & ~wmask[3:0]) | (wdata_q[3:0] & wmask[3:0]);
            end
            irq_stat_q <= irq_stat_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_manual_rst_low: assert property (!man_rst_s && margin_n |=> !rst_out_q)
        else $error("manual reset did not pull reset low");
    a_manual_stretch: assert property ($rose(man_rst_s) && (&chan_s) && margin_n
        && rst_limit > 32'h2 ##1 margin_n && rst_limit > 32'h2
        |-> !rst_out_q ##1 !rst_out_q)
        else $error("reset released too soon after manual reset");
    a_chan_flag: assert property (margin_n |=> flag_q == $past(chan_s))
        else $error("channel flag does not follow its channel");
    a_margin_high: assert property (!margin_n |=> rst_out_q && (&flag_q))
        else $error("outputs not high during margin");
    a_cause_holds: assert property (cause |=> state_q == svr_pkg::RS_HOLD)
        else $error("channel fault did not hold reset");
    a_wd_rst_clear: assert property (rst_asserted || kick_edge |=> wd_cnt_q == 32'h0)
        else $error("watchdog not cleared");
    a_wd_expire_rst: assert property (wd_expire && !cause
        |=> state_q == svr_pkg::RS_STRETCH && st_cnt_q == 32'h0 && wd_cnt_q == 32'h0)
        else $error("watchdog expiry did not start reset");
    a_wd_disabled: assert property (!wd_active |-> !wd_expire ##1 wd_cnt_q == 32'h0)
        else $error("watchdog ran while disabled");
    a_startup_win: assert property (!started_q |-> wd_limit == STARTUP_CYCLES)
        else $error("startup window not applied");
    a_int_timeout: assert property (timeout_select |-> rst_limit == INT_RST_CYCLES)
        else $error("internal reset timeout not used");
    a_cap_timeout: assert property (!timeout_select && cap_cyc != 32'h0
        |-> rst_limit == cap_q[23:0] * 32'd103)
        else $error("capacitor timeout wrong");
    a_sync_manual: assert property (##2 man_rst_s == $past(manual_reset_n, 2))
        else $error("manual reset not synchronised");
endmodule
`default_nettype wire

//--- hw/svr_pkg.sv
// Constants for the supervisor watchdog reset block: timing, register map, states.
// Assumes a 50 MHz core clock; all counts are in cycles of that clock.
package svr_pkg;

    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned WDOG_TIMEOUT_MS = 1600;
    localparam int unsigned STARTUP_S       = 54;
    localparam int unsigned INT_RST_MS      = 140;
    // Timing resistor of the capacitor mode, 2.06 Mohm
    localparam int unsigned TMO_R_KOHM      = 2060;

    localparam logic [31:0] WDOG_CYC    = 32'(64'(WDOG_TIMEOUT_MS) * CLK_HZ / 1000);
    localparam logic [31:0] STARTUP_CYC = 32'(64'(STARTUP_S) * CLK_HZ);
    localparam logic [31:0] INT_RST_CYC = 32'((64'(INT_RST_MS) * CLK_HZ + 999) / 1000);
    // Cycles per picofarad of timing capacitance
    localparam logic [31:0] CYC_PER_PF  = 32'(64'(TMO_R_KOHM) * CLK_HZ / 1_000_000_000);

    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_TMO_CAP  = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h14;

    localparam int unsigned CTRL_WDOG_EN = 0;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
    localparam int unsigned CAP_W        = 24;
    localparam logic [31:0] TMO_CAP_RST  = 32'h0001_0000;

    localparam int unsigned IRQ_WDOG = 0;
    localparam int unsigned IRQ_CHAN = 1;
    localparam int unsigned IRQ_MANUAL = 2;
    localparam int unsigned IRQ_REL  = 3;
    localparam int unsigned IRQ_W    = 4;

    localparam int unsigned ST_CHAN    = 0;
    localparam int unsigned ST_RST     = 4;
    localparam int unsigned ST_STARTUP = 5;
    localparam int unsigned ST_WD_OFF  = 6;
    localparam int unsigned ST_MARGIN  = 7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RS_HOLD,
        RS_STRETCH,
        RS_RUN
    } svr_rst_state_t;

endpackage

//--- hw/svr_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the destination clock is the core clock.
`timescale 1ns/1ps
`default_nettype none
module svr_sync #(
    parameter int unsigned W            = 1,
    parameter logic [W-1:0] INIT        = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= INIT;
            q      <= INIT;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- tb/svr_host_model.sv
// Host model: takes the system reset and toggles the watchdog kick.
// Assumes the core clock; kicks only while enabled and out of reset.
`timescale 1ns/1ps
`default_nettype none
module svr_host_model (
    input  wire logic       mclk,
    input  wire logic       sys_reset_n,
    input  wire logic       kick_en,
    input  wire logic [7:0] period,
    output logic            watchdog_kick_in
);
    logic [7:0] cnt_q;
    initial begin
        watchdog_kick_in = 1'b0;
        cnt_q = 8'h00;
    end
    // First kick well inside the startup window, then one every period+1 cycles
    always @(posedge mclk) begin
        if (!sys_reset_n || !kick_en) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= period) begin
            cnt_q <= 8'h00;
            watchdog_kick_in <= ~watchdog_kick_in;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Bench for the supervisor core: flags, reset stretch, watchdog, registers.
// Assumes shortened timing parameters and the host model on the kick pin.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] RT  = 32'h14;
    // 2.06 Mohm * 1 pF at 50 MHz
    localparam int          CAP = 103;
    logic        mclk, rst_n, wd_open, man_rst_n, tsel, margin_n, kick_en, kick;
    logic [3:0]  mon, flg;
    logic [7:0]  period, awaddr, araddr;
    logic        sys_n, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp;
    int          num_errors, compares;

    svr_top #(.WDOG_CYCLES(32'h28), .STARTUP_CYCLES(32'h64), .INT_RST_CYCLES(RT)) uut (
        .mclk(mclk), .rst_n(rst_n), .monitor_chan_5(mon[0]), .monitor_chan_6(mon[1]),
        .monitor_chan_7(mon[2]), .monitor_chan_8(mon[3]), .watchdog_kick_in(kick),
        .watchdog_open(wd_open), .manual_reset_n(man_rst_n), .timeout_select(tsel),
        .margin_n(margin_n), .chan_fault_flag_5(flg[0]), .chan_fault_flag_6(flg[1]),
        .chan_fault_flag_7(flg[2]), .chan_fault_flag_8(flg[3]), .sys_reset_n(sys_n),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    svr_host_model host (.mclk(mclk), .sys_reset_n(sys_n), .kick_en(kick_en),
        .period(period), .watchdog_kick_in(kick));

    task automatic final_report();
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tmo();
        num_errors++;
        final_report();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wait_rst(input logic lvl, input int lim);
        int n;
        n = 0;
        while (sys_n !== lvl) begin
            cyc(1);
            n++;
            if (n > lim) tmo();
        end
    endtask
    // Reset output still low late in the timeout, then released
    task automatic stretch(input int n);
        cyc(n - 6);
        chk({31'h0, sys_n}, 32'h0);
        wait_rst(1'b1, 20);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
            if (n > 50) tmo();
        end while (!bvalid);
        bready <= 1'b0;
        resp = bresp;
        #1;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            n++;
            if (n > 50) tmo();
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
        #1;
    endtask
    task automatic pin(input logic [2:0] sel, input logic v);
        @(posedge mclk);
        case (sel)
            3'h0: man_rst_n <= v;
            3'h1: margin_n <= v;
            3'h2: tsel <= v;
            3'h3: kick_en <= v;
            default: wd_open <= v;
        endcase
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        {rst_n, wd_open, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {man_rst_n, tsel, margin_n, kick_en} = 4'hf;
        mon = 4'hf;
        period = 8'h0f;
        {awaddr, araddr, wdata} = 48'h0;
        num_errors = 0;
        compares = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk({27'h0, sys_n, flg}, 32'h0f);
        stretch(RT);
        axi_rd(svr_pkg::OFS_CTRL);
        chk(rd, svr_pkg::CTRL_RST);
        axi_rd(8'h40);
        chk({rd[29:0], resp}, {30'h0, svr_pkg::RESP_SLVERR});
        axi_wr(svr_pkg::OFS_IRQ_EN, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            mon[i] <= 1'b0;
            cyc(5);
            chk({27'h0, sys_n, flg}, {28'h0, ~(4'h1 << i)});
            @(posedge mclk);
            mon[i] <= 1'b1;
            cyc(4);
            chk({28'h0, flg}, 32'hf);
            stretch(RT);
        end
        chk({31'h0, irq}, 32'h0);
        axi_rd(svr_pkg::OFS_IRQ_STAT);
        chk(rd & 32'h2, 32'h2);
        axi_wr(svr_pkg::OFS_IRQ_EN, 32'h2);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        axi_wr(svr_pkg::OFS_IRQ_CLR, 32'h2);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        pin(3'h0, 1'b0);
        cyc(5);
        chk({31'h0, sys_n}, 32'h0);
        cyc(50);
        chk({31'h0, sys_n}, 32'h0);
        pin(3'h0, 1'b1);
        stretch(RT);
        mon[0] <= 1'b0;
        pin(3'h1, 1'b0);
        cyc(5);
        chk({27'h0, sys_n, flg}, 32'h1f);
        pin(3'h1, 1'b1);
        cyc(2);
        chk({27'h0, sys_n, flg}, 32'h0e);
        mon[0] <= 1'b1;
        stretch(RT);
        axi_wr(svr_pkg::OFS_TMO_CAP, 32'h1);
        chk({30'h0, resp}, {30'h0, svr_pkg::RESP_OKAY});
        pin(3'h2, 1'b0);
        pin(3'h0, 1'b0);
        cyc(5);
        pin(3'h0, 1'b1);
        stretch(CAP);
        pin(3'h2, 1'b1);
        period <= 8'h1e;
        cyc(200);
        chk({31'h0, sys_n}, 32'h1);
        period <= 8'h0f;
        cyc(40);
        pin(3'h3, 1'b0);
        cyc(15);
        chk({31'h0, sys_n}, 32'h1);
        wait_rst(1'b0, 40);
        wait_rst(1'b1, 40);
        cyc(80);
        chk({31'h0, sys_n}, 32'h1);
        wait_rst(1'b0, 40);
        pin(3'h4, 1'b1);
        wait_rst(1'b1, 40);
        cyc(300);
        chk({31'h0, sys_n}, 32'h1);
        axi_wr(svr_pkg::OFS_CTRL, 32'h0);
        pin(3'h4, 1'b0);
        cyc(300);
        chk({31'h0, sys_n}, 32'h1);
        axi_rd(svr_pkg::OFS_CTRL);
        chk(rd, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
